// ---- hdl/conv_trigger_ctrl.v ----
// converter control: channel routing, power, clock division, software and hardware start
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "conv_ctrl_regs.vh"
module conv_trigger_ctrl #(
   parameter CONV_TICKS = 16,
   parameter RES_W      = 12
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // register port
   input  wire [7:0]       addr,
   input  wire [7:0]       wdata,
   input  wire             wr,
   input  wire             rd,
   output reg  [7:0]       rdata_q,
   // pwm unit
   input  wire             pwm_ch0,
   input  wire             pwm_ch2,
   input  wire             pwm_ch4,
   input  wire             pwm_centre_pulse,
   input  wire             pwm_end_pulse,
   // external start pin candidates
   input  wire             port_p0_4,
   input  wire             port_p1_3,
   // analog converter core
   output wire             converter_power,
   output wire [8:0]       channel_connect,
   output wire             conv_clk_en,
   output reg              conv_start_q,
   input  wire [RES_W-1:0] core_result,
   input  wire             core_done,
   input  wire             core_done_valid,
   // interrupt
   output wire             irq
);

   // control registers
   reg       flag_q;
   reg       busy_q;
   reg [1:0] src_q;
   reg [3:0] chan_q;
   reg       unused_q;
   reg       pinloc_q;
   reg [1:0] div_q;
   reg [1:0] typ_q;
   reg       hwtrig_q;
   reg       enable_q;
   reg [RES_W-1:0]    result_q;
   reg [`IRQ_W-1:0]   int_stat_q;
   reg [`IRQ_W-1:0]   int_mask_q;

   // trigger path
   reg  pin_meta_q;
   reg  pin_sync_q;
   reg  trig_prev_q;
   reg  trig_level;
   reg  hw_event;
   wire pin_raw;

   // conversion sequencing
   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] tick_cnt_q;
   wire      conv_tick;
   wire      sw_start;
   wire      start;
   wire      done;
   wire      hw_start;
   wire      converting;

   // last tick index of an internally timed conversion, cut to the counter width on purpose;
   // a tick count above the counter range would wrap, so keep it small
   localparam [31:0] TICKS_32  = CONV_TICKS;
   localparam [7:0]  LAST_TICK = TICKS_32[7:0] - 8'h01;

   // register write decode, shared by the control, flag and interrupt register processes
   wire      wr_ctrl0;
   wire      wr_ctrl1;
   wire      wr_stat;
   wire      wr_mask;
   wire      clr_done;
   wire      clr_trig;

   // read multiplexer output, registered one cycle later
   reg [7:0] rd_mux;

   // one-hot decode of the channel field
   function [`CHAN_ONEHOT_W-1:0] chan_decode;
      input [3:0] code;
      begin
         if (code <= `CHAN_BANDGAP)
            chan_decode = {{(`CHAN_ONEHOT_W-1){1'b0}}, 1'b1} << code;
         else
            chan_decode = {`CHAN_ONEHOT_W{1'b0}};
      end
   endfunction

   // register write decode helper
   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // sticky status bit: a new event wins over a write-one clear in the same cycle,
   // otherwise a clear racing a completion would swallow the event
   function sticky;
      input old;
      input set;
      input clr;
      begin
         sticky = set || (old && !clr);
      end
   endfunction

   // edge of a sampled level in the direction asked for
   function edge_seen;
      input prev;
      input now;
      input rising;
      begin
         edge_seen = rising ? (!prev && now) : (prev && !now);
      end
   endfunction

   // write decode and the hardware-start marker for the status register
   assign wr_ctrl0   = wr && hit(addr, `ADDR_CTRL_ZERO);
   assign wr_ctrl1   = wr && hit(addr, `ADDR_CTRL_ONE);
   assign wr_stat    = wr && hit(addr, `ADDR_INT_STATUS);
   assign wr_mask    = wr && hit(addr, `ADDR_INT_MASK);
   assign clr_done   = wr_stat && wdata[`IRQ_DONE_BIT];
   assign clr_trig   = wr_stat && wdata[`IRQ_TRIG_BIT];
   assign hw_start   = start && !sw_start;
   assign converting = (state_q == ST_CONV);

   // power and channel routing; disabled converter disconnects everything
   assign converter_power = enable_q;
   assign channel_connect = enable_q ? chan_decode(chan_q) : {`CHAN_ONEHOT_W{1'b0}};

   // pin location mux in front of the synchroniser, no deferral
   assign pin_raw = pinloc_q ? port_p1_3 : port_p0_4;

   // two-stage synchroniser; only the second stage is looked at
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   // selected trigger level
   always @* begin
      case (src_q)
         `SRC_PWM_CH0:   trig_level = pwm_ch0;
         `SRC_PWM_CH2:   trig_level = pwm_ch2;
         `SRC_PWM_CH4:   trig_level = pwm_ch4;
         `SRC_START_PIN: trig_level = pin_sync_q;
         default:        trig_level = 1'b0;
      endcase
   end

   // previous level kept every cycle so a source switch can give one spurious edge;
   // software should change the source with the hardware trigger off
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         trig_prev_q <= 1'b0;
      else
         trig_prev_q <= trig_level;
   end

   // trigger condition; centre and end points come only in centre-aligned pwm mode
   always @* begin
      case (typ_q)
         `TYP_FALL:   hw_event = edge_seen(trig_prev_q, trig_level, 1'b0);
         `TYP_RISE:   hw_event = edge_seen(trig_prev_q, trig_level, 1'b1);
         `TYP_CENTRE: hw_event = pwm_centre_pulse;
         `TYP_END:    hw_event = pwm_end_pulse;
         default:     hw_event = 1'b0;
      endcase
   end

   // start decision: software write of 1 to busy bit, or hardware event when selected;
   // both in one cycle make a single start, which is counted as a software one
   assign sw_start = wr_ctrl0 && wdata[`C0_BUSY_BIT];
   assign start    = enable_q && !busy_q && !flag_q &&
                     (sw_start || (hwtrig_q && hw_event));

   // completion from the core, or from the internal tick count when no core reply
   assign done = busy_q && (core_done_valid ? core_done
                                            : (conv_tick && tick_cnt_q == LAST_TICK));

   // converter clock divider
   conv_clk_div #(
      .CNT_W (3)
   ) u_div (
      .clk         (clk),
      .reset_n     (reset_n),
      .run         (enable_q),
      .div_sel     (div_q),
      .conv_tick_q (conv_tick)
   );
   assign conv_clk_en = conv_tick;

   // sequencer next state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (start) state_d = ST_CONV;
         ST_CONV: if (done || !enable_q) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // sequencer state
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // start pulse to the core, one cycle after the start is taken
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         conv_start_q <= 1'b0;
      else
         conv_start_q <= start;
   end

   // converter ticks counted from the start of the current conversion;
   // an aborted conversion leaves the count behind, the next start reloads it
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         tick_cnt_q <= 8'h00;
      else if (start)
         tick_cnt_q <= 8'h00;
      else if (converting && conv_tick)
         tick_cnt_q <= tick_cnt_q + 8'h01;
   end

   // control zero fields written by software
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         src_q  <= 2'h0;
         chan_q <= 4'h0;
      end else if (wr_ctrl0) begin
         src_q  <= wdata[`C0_SRC_HI:`C0_SRC_LO];
         chan_q <= wdata[`C0_CHAN_HI:`C0_CHAN_LO];
      end
   end

   // completion flag: completion wins over a software clear in the same cycle
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         flag_q <= 1'b0;
      else if (done)
         flag_q <= 1'b1;
      else if (wr_ctrl0 && !wdata[`C0_FLAG_BIT])
         flag_q <= 1'b0;
   end

   // busy bit: set by any accepted start, dropped on completion or power-down
   // so that a disabled converter reports itself busy for at most one cycle
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         busy_q <= 1'b0;
      else if (start)
         busy_q <= 1'b1;
      else if (done || !enable_q)
         busy_q <= 1'b0;
   end

   // control one
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unused_q <= 1'b0;
         pinloc_q <= 1'b0;
         div_q    <= 2'h0;
         typ_q    <= 2'h0;
         hwtrig_q <= 1'b0;
         enable_q <= 1'b0;
      end else if (wr_ctrl1) begin
         unused_q <= wdata[`C1_UNUSED_BIT];
         pinloc_q <= wdata[`C1_PINLOC_BIT];
         div_q    <= wdata[`C1_DIV_HI:`C1_DIV_LO];
         typ_q    <= wdata[`C1_TYPE_HI:`C1_TYPE_LO];
         hwtrig_q <= wdata[`C1_HWTRIG_BIT];
         enable_q <= wdata[`C1_ENABLE_BIT];
      end
   end

   // result capture on completion
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         result_q <= {RES_W{1'b0}};
      else if (done)
         result_q <= core_result;
   end

   // interrupt status, write one to clear, new events win over the clear
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_stat_q <= {`IRQ_W{1'b0}};
         int_mask_q <= {`IRQ_W{1'b0}};
      end else begin
         if (wr_mask)
            int_mask_q <= wdata[`IRQ_W-1:0];
         int_stat_q[`IRQ_DONE_BIT] <= sticky(int_stat_q[`IRQ_DONE_BIT], done, clr_done);
         int_stat_q[`IRQ_TRIG_BIT] <= sticky(int_stat_q[`IRQ_TRIG_BIT], hw_start, clr_trig);
      end
   end
   assign irq = |(int_stat_q & int_mask_q);

   // read multiplexer; unmapped addresses read zero
   always @* begin
      case (addr)
         `ADDR_CTRL_ZERO:  rd_mux = {flag_q, busy_q, src_q, chan_q};
         `ADDR_CTRL_ONE:   rd_mux = {unused_q, pinloc_q, div_q, typ_q, hwtrig_q, enable_q};
         `ADDR_RESULT_HI:  rd_mux = result_q[RES_W-1:RES_W-8];
         `ADDR_RESULT_LO:  rd_mux = {4'h0, result_q[3:0]};
         `ADDR_INT_STATUS: rd_mux = {6'h00, int_stat_q};
         `ADDR_INT_MASK:   rd_mux = {6'h00, int_mask_q};
         default:          rd_mux = `RST_BYTE;
      endcase
   end

   // read data one cycle after the strobe and zero otherwise, so a stale value is never seen
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rdata_q <= `RST_BYTE;
      else if (rd)
         rdata_q <= rd_mux;
      else
         rdata_q <= `RST_BYTE;
   end

endmodule

// ---- include/conv_ctrl_regs.vh ----
// register offsets, field positions and constants of the converter trigger and channel control block
//
// Contract
// - trigger source field picks pwm channel 0, 2, 4 or external start pin.
// - channel field codes 0-7 route analog inputs, 8 the band-gap, others reserved.
// - with converter disabled every analog input is disconnected.
// - start pin location bit selects port pin P0.4 (0) or P1.3 (1).
// - a change of start pin location takes effect immediately.
// - clock divider field divides system clock by 1, 2, 4 or 8.
// - trigger type 00 starts on falling edge, 01 on rising edge.
// - trigger type 10 starts at pwm period centre, 11 at period end.
// - trigger source and type act only while hardware trigger select is set.
// - hardware trigger select 0 means only software start bit starts conversions.
// - hardware trigger select 1 allows software start or chosen hardware trigger.
// - while busy, further hardware triggers are dropped silently.
// - converter enable bit powers converter off at 0, on at 1.
// - a hardware trigger start also sets the busy start bit.
// - on completion clear busy, set flag, store 12-bit result, raise interrupt.
// - while completion flag is 1 no new conversion begins.
`ifndef CONV_CTRL_REGS_VH
`define CONV_CTRL_REGS_VH

// register addresses on the 8-bit register port
`define ADDR_CTRL_ZERO    8'hE8
`define ADDR_CTRL_ONE     8'hE1
`define ADDR_RESULT_HI    8'hC3
`define ADDR_RESULT_LO    8'hC2
`define ADDR_INT_STATUS   8'hC4
`define ADDR_INT_MASK     8'hC5

// converter_control_zero fields
`define C0_FLAG_BIT       7
`define C0_BUSY_BIT       6
`define C0_SRC_HI         5
`define C0_SRC_LO         4
`define C0_CHAN_HI        3
`define C0_CHAN_LO        0

// converter_control_one fields
`define C1_UNUSED_BIT     7
`define C1_PINLOC_BIT     6
`define C1_DIV_HI         5
`define C1_DIV_LO         4
`define C1_TYPE_HI        3
`define C1_TYPE_LO        2
`define C1_HWTRIG_BIT     1
`define C1_ENABLE_BIT     0

// reset values
`define RST_CTRL_ZERO     8'h00
`define RST_CTRL_ONE      8'h00
`define RST_BYTE          8'h00

// trigger source codes
`define SRC_PWM_CH0       2'h0
`define SRC_PWM_CH2       2'h1
`define SRC_PWM_CH4       2'h2
`define SRC_START_PIN     2'h3

// trigger type codes
`define TYP_FALL          2'h0
`define TYP_RISE          2'h1
`define TYP_CENTRE        2'h2
`define TYP_END           2'h3

// channel codes
`define CHAN_LAST_PIN     4'h7
`define CHAN_BANDGAP      4'h8
`define CHAN_ONEHOT_W     9

// interrupt status bit positions
`define IRQ_DONE_BIT      0
`define IRQ_TRIG_BIT      1
`define IRQ_W             2

`endif

// ---- hdl/conv_clk_div.v ----
// programmable divider producing the converter clock enable from the system clock
`timescale 1ns/10ps
module conv_clk_div #(
   parameter CNT_W = 3
) (
   // clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // control
   input  wire       run,
   input  wire [1:0] div_sel,
   // output
   output reg        conv_tick_q
);

   reg  [CNT_W-1:0] cnt_q;
   reg  [CNT_W-1:0] cnt_d;
   wire [CNT_W-1:0] term;

   // terminal count: 2**div_sel - 1 gives divide by 1, 2, 4, 8
   assign term = ({{(CNT_W-1){1'b0}}, 1'b1} << div_sel) - {{(CNT_W-1){1'b0}}, 1'b1};

   // count resets while stopped, so ticks align to the enable; a conversion start does not realign them
   always @* begin
      if (!run || cnt_q >= term)
         cnt_d = {CNT_W{1'b0}};
      else
         cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
   end

   // tick register
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q       <= {CNT_W{1'b0}};
         conv_tick_q <= 1'b0;
      end else begin
         cnt_q       <= cnt_d;
         conv_tick_q <= run && (cnt_q >= term);
      end
   end

endmodule

// ---- verif/conv_ctrl_props.sv ----
// concurrent checks on the converter control block ports
`timescale 1ns/10ps
`include "conv_ctrl_regs.vh"
module conv_ctrl_props #(
   parameter CONV_TICKS = 16
) (
   // clock and reset
   input wire       clk,
   input wire       reset_n,
   // register port
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata_q,
   // converter and interrupt
   input wire       converter_power,
   input wire [8:0] channel_connect,
   input wire       conv_clk_en,
   input wire       conv_start_q,
   input wire       irq
);
   reg       hw_q;
   reg [1:0] div_q;
   wire      w0 = wr && addr == `ADDR_CTRL_ZERO;
   wire      w1 = wr && addr == `ADDR_CTRL_ONE;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // software view of trigger mode and divider, so checks follow what was written
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hw_q  <= 1'b0;
         div_q <= 2'h0;
      end else if (w1) begin
         hw_q  <= wdata[1];
         div_q <= wdata[5:4];
      end
   end
   a_power_follows: assert property (w1 |=> converter_power == $past(wdata[0]))
      else $error("power bit wrong");
   a_off_no_path: assert property (!converter_power |-> channel_connect == 9'h000)
      else $error("input routed while off");
   a_channel_route: assert property (w0 && converter_power |=>
      channel_connect == ($past(wdata[3:0]) > 4'h8 ? 9'h000 : 9'h001 << $past(wdata[3:0])))
      else $error("channel routing wrong");
   a_tick_off: assert property (!converter_power && !$past(converter_power) |-> !conv_clk_en)
      else $error("tick while off");
   a_tick_gap: assert property (conv_clk_en && div_q != 2'h0 && $past(div_q, 3) == div_q |=> !conv_clk_en)
      else $error("ticks too close");
   a_start_cause: assert property (conv_start_q |-> $past(w0) && $past(wdata[6]) || $past(hw_q))
      else $error("start without cause");
   a_start_gap: assert property (conv_start_q |=> (!conv_start_q)[*3])
      else $error("starts too close");
   a_irq_masked: assert property (wr && addr == `ADDR_INT_MASK && wdata[1:0] == 2'h0 |=> !irq)
      else $error("masked interrupt seen");
   a_read_idle: assert property (!$past(rd) |-> rdata_q == 8'h00)
      else $error("read data outside slot");
   // main scenarios reached
   c_hw_start: cover property (conv_start_q && hw_q);
   c_irq: cover property (irq);
   c_slow_tick: cover property (conv_clk_en && div_q == 2'h3);
endmodule

// ---- verif/conv_far_side.sv ----
// far-side model: pwm levels and period strobes, start pins, converter core
`timescale 1ns/10ps
module conv_far_side (
   // clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // bench control
   input  wire [4:0] lvl,
   input  wire [1:0] pt_req,
   input  wire [3:0] lat,
   // pwm unit and start pins
   output reg  [2:0] pwm,
   output reg  [1:0] pt,
   output reg  [1:0] pins,
   // converter core
   input  wire       conv_start_q,
   input  wire       conv_clk_en,
   output reg        core_done
);
   reg [3:0] cnt_q;
   // strobes last one cycle; centre and end points exist only for a centre-aligned pwm
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {pins, pwm, pt, core_done, cnt_q} <= 12'h000;
      end else begin
         {pins, pwm} <= lvl;
         pt <= pt_req & ~pt;
         core_done <= cnt_q == 4'h1 && conv_clk_en;
         if (conv_start_q)
            cnt_q <= lat;
         else if (conv_clk_en && cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule

// ---- verif/conv_trigger_ctrl_tb.sv ----
// self-checking bench for the converter trigger and channel control
`timescale 1ns/10ps
`include "conv_ctrl_regs.vh"
module conv_trigger_ctrl_tb;
   reg         clk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [7:0]  addr = 8'h00;
   reg  [7:0]  wdata = 8'h00;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   reg  [4:0]  lvl = 5'h00;
   reg  [1:0]  pt_req = 2'h0;
   reg  [3:0]  lat = 4'h3;
   reg  [11:0] core_result = 12'h000;
   reg         core_done_valid = 1'b1;
   wire [7:0]  rdata_q;
   wire [2:0]  pwm;
   wire [1:0]  pt, pins;
   wire [8:0]  channel_connect;
   wire        converter_power, conv_clk_en, conv_start_q, core_done, irq;
   integer     seed = 77897, failures = 0, samples_checked = 0, n_start = 0;
   integer     i, s, t, n0;
   reg  [7:0]  d;
   reg  [5:0]  c0;
   reg  [1:0]  m;
   conv_trigger_ctrl #(.CONV_TICKS(4)) dut_u (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata_q,
      .pwm_ch0(pwm[0]), .pwm_ch2(pwm[1]), .pwm_ch4(pwm[2]), .pwm_centre_pulse(pt[0]),
      .pwm_end_pulse(pt[1]), .port_p0_4(pins[0]), .port_p1_3(pins[1]), .converter_power,
      .channel_connect, .conv_clk_en, .conv_start_q, .core_result, .core_done, .core_done_valid, .irq);
   conv_far_side far_u (.clk, .reset_n, .lvl, .pt_req, .lat, .pwm, .pt, .pins, .conv_start_q,
      .conv_clk_en, .core_done);
   // 40 MHz clock and a count of accepted starts
   always #12.5 clk = ~clk;
   always @(posedge clk) if (conv_start_q) n_start <= n_start + 1;
   function [8:0] conn_exp(input [3:0] c);
      conn_exp = c < 4'h9 ? 9'h001 << c : 9'h000;
   endfunction
   // line index of the chosen trigger and of one that must be ignored
   function integer sel(input integer s, input integer t);
      sel = t > 1 ? t - 2 : s;
   endfunction
   function integer other(input integer s, input integer t);
      other = t > 1 ? 3 - t : (s + 1) % 5;
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task wreg(input [7:0] a, input [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task rreg(input [7:0] a, output [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata_q;
   endtask
   // one trigger event: a level toggle, or a period strobe
   task fire(input integer b, input integer t);
      @(posedge clk);
      if (t > 1) pt_req[b] <= 1'b1;
      else lvl[b] <= ~lvl[b];
      @(posedge clk);
      pt_req <= 2'h0;
      repeat (8) @(posedge clk);
   endtask
   // wait for completion, check flag, status, result and interrupt, then clear
   task finish_conv(input hw);
      integer j;
      d = 8'h00;
      for (j = 0; j < 80 && !d[7]; j++) rreg(`ADDR_CTRL_ZERO, d);
      chk(d[7:6], 2'h2);
      chk(irq, m[0] | (m[1] & hw));
      rreg(`ADDR_INT_STATUS, d);
      chk(d[1:0], {hw, 1'b1});
      rreg(`ADDR_RESULT_HI, d);
      chk(d, core_result[11:4]);
      rreg(`ADDR_RESULT_LO, d);
      chk(d, {4'h0, core_result[3:0]});
      wreg(`ADDR_CTRL_ZERO, {2'h0, c0});
      wreg(`ADDR_INT_STATUS, 8'h03);
      @(negedge clk);
      chk(irq, 1'b0);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // cut a hang short
   initial begin
      #1000000;
      failures++;
      print_verdict;
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rreg(`ADDR_CTRL_ZERO, d);
      chk(d, `RST_CTRL_ZERO);
      rreg(`ADDR_CTRL_ONE, d);
      chk(d, `RST_CTRL_ONE);
      wreg(8'h00, 8'hFF);
      rreg(8'h00, d);
      chk(d, 8'h00);
      // every channel code with the converter on, then power off
      wreg(`ADDR_CTRL_ONE, 8'h01);
      for (i = 0; i < 16; i++) begin
         wreg(`ADDR_CTRL_ZERO, i[7:0]);
         @(negedge clk);
         chk(channel_connect, conn_exp(i[3:0]));
      end
      wreg(`ADDR_CTRL_ZERO, 8'h08);
      @(negedge clk);
      chk(channel_connect, 9'h100);
      wreg(`ADDR_CTRL_ONE, 8'h00);
      @(negedge clk);
      chk({converter_power, channel_connect}, 10'h000);
      // converter tick spacing for every divider code
      for (i = 0; i < 4; i++) begin
         wreg(`ADDR_CTRL_ONE, {2'h0, i[1:0], 4'h1});
         repeat (9) @(posedge clk);
         for (t = 0; t < 20 && !conv_clk_en; t++) @(posedge clk);
         @(posedge clk);
         for (t = 1; t < 20 && !conv_clk_en; t++) @(posedge clk);
         chk(t, 1 << i);
      end
      // software starts, a repeated start while busy, both completion modes
      for (i = 0; i < 3; i++) begin
         c0 = $random(seed);
         m = $random(seed);
         wreg(`ADDR_CTRL_ONE, {2'h0, i[1:0], 4'h1});
         core_done_valid <= i[0];
         core_result <= $random(seed);
         wreg(`ADDR_INT_MASK, {6'h00, m});
         n0 = n_start;
         wreg(`ADDR_CTRL_ZERO, {2'h1, c0});
         wreg(`ADDR_CTRL_ZERO, {2'h1, c0});
         finish_conv(1'b0);
         chk(n_start - n0, 1);
      end
      // every source, pin location and trigger type
      for (s = 0; s < 5; s++) for (t = 0; t < 4; t++) begin
         c0 = $random(seed);
         c0[5:4] = s == 4 ? 2'h3 : s[1:0];
         m = $random(seed);
         wreg(`ADDR_CTRL_ONE, {1'b0, s == 4, 2'h3, t[1:0], 2'h1});
         lvl <= {5{t == 0}};
         lat <= 4'hF;
         core_result <= $random(seed);
         wreg(`ADDR_INT_MASK, {6'h00, m});
         wreg(`ADDR_CTRL_ZERO, {2'h0, c0});
         n0 = n_start;
         fire(sel(s, t), t);
         fire(sel(s, t), t);
         chk(n_start - n0, 0);
         wreg(`ADDR_CTRL_ONE, {1'b0, s == 4, 2'h3, t[1:0], 2'h3});
         fire(other(s, t), t);
         chk(n_start - n0, 0);
         fire(sel(s, t), t);
         chk(n_start - n0, 1);
         rreg(`ADDR_CTRL_ZERO, d);
         chk(d[6], 1'b1);
         fire(sel(s, t), t);
         fire(sel(s, t), t);
         chk(n_start - n0, 1);
         finish_conv(1'b1);
      end
      print_verdict;
   end
endmodule
bind conv_trigger_ctrl conv_ctrl_props #(.CONV_TICKS(CONV_TICKS)) props_u (.clk, .reset_n, .addr, .wdata,
   .wr, .rd, .rdata_q, .converter_power, .channel_connect, .conv_clk_en, .conv_start_q, .irq);
